// ### src/irq_prio_pkg.sv
// Constants for the interrupt priority and CPU target register arrays.
// Assumes a 12-bit APB byte address, 32-bit data and a two-processor build.
package irq_prio_pkg;
   // Sizing
   localparam int INTERRUPT_LINE_GROUPS = 1;
   localparam int NUM_IRQ               = 32 * (INTERRUPT_LINE_GROUPS + 1);
   localparam int NUM_REGS              = 8 * (INTERRUPT_LINE_GROUPS + 1);
   localparam int NUM_SPI               = NUM_IRQ - 32;
   localparam int LANES                 = 4;
   localparam int ADDR_W                = 12;
   localparam int CPU_ID_W              = 1;
   // Register windows, byte addresses
   localparam logic [11:0] PRIO_BASE    = 12'h400;
   localparam logic [11:0] PRIO_LAST    = 12'h7FC;
   localparam logic [11:0] TARGET_BASE  = 12'h800;
   localparam logic [11:0] TARGET_LAST  = 12'hBFC;
   // Field masks and reset values
   localparam logic [7:0]  PRIO_MASK    = 8'hF8;
   localparam logic [7:0]  PRIO_NS_TOP  = 8'h80;
   localparam logic [7:0]  CPU_MASK     = 8'h03;
   localparam logic [7:0]  OWN_CPU_BASE = 8'h01;
   localparam logic [7:0]  PRIO_RESET   = 8'h00;
   localparam logic [7:0]  TARGET_RESET = 8'h00;
   localparam logic [31:0] RAZ_WORD     = 32'h0000_0000;
   // Build options
   localparam logic        MULTI_PROC   = 1'b1;
   localparam logic        SECURITY     = 1'b1;
   localparam logic [63:0] IMPLEMENTED  = 64'h0FFF_FFFF_F800_FFFF;
   localparam logic [31:0] STATIC_SPI_MASK   = 32'h0000_0001;
   localparam logic [7:0]  STATIC_SPI_TARGET = 8'h02;
   localparam logic [31:0] LOCKABLE_SPI_MASK = 32'h0000_FFFF;
endpackage

// ### src/lane_if.sv
// Per byte lane access bundle between the register file and a lane unit.
// Assumes the register file drives the context and the lane unit answers.
`timescale 1ns/1ps
interface lane_if;
   logic       is_target;
   logic       nonsecure;
   logic       implemented;
   logic       group0;
   logic       banked;
   logic       fixed;
   logic       locked;
   logic [7:0] wbyte;
   logic [7:0] stored;
   logic [7:0] own_cpu_bits;
   logic [7:0] rd_byte;
   logic       wr_ok;
   logic [7:0] wr_byte;

   modport regs (output is_target, nonsecure, implemented, group0, banked, fixed, locked,
                 output wbyte, stored, own_cpu_bits,
                 input  rd_byte, wr_ok, wr_byte);
   modport lane (input  is_target, nonsecure, implemented, group0, banked, fixed, locked,
                 input  wbyte, stored, own_cpu_bits,
                 output rd_byte, wr_ok, wr_byte);
endinterface

// ### src/irq_lane_access.sv
// Read and write view of one priority or target byte field.
// Assumes the context signals are valid for the whole APB transfer.
`timescale 1ns/1ps
module irq_lane_access (
   // Lane bundle
   lane_if.lane port
);
   logic [7:0] masked_prio;

   always_comb begin
      masked_prio  = port.stored & irq_prio_pkg::PRIO_MASK;
      port.rd_byte = 8'h00;
      port.wr_ok   = 1'b0;
      port.wr_byte = 8'h00;
      // Unimplemented fields and non-secure views of group 0 stay silent
      if (port.implemented && !(port.nonsecure && port.group0)) begin
         if (!port.is_target) begin
            port.wr_ok = 1'b1;
            if (port.nonsecure) begin
               port.rd_byte = {masked_prio[6:0], 1'b0};
               port.wr_byte = (irq_prio_pkg::PRIO_NS_TOP | {1'b0, port.wbyte[7:1]})
                              & irq_prio_pkg::PRIO_MASK;
            end else begin
               port.rd_byte = masked_prio;
               port.wr_byte = port.wbyte & irq_prio_pkg::PRIO_MASK;
            end
         end else if (port.banked) begin
            port.rd_byte = port.own_cpu_bits;
         end else if (port.fixed) begin
            port.rd_byte = irq_prio_pkg::STATIC_SPI_TARGET & irq_prio_pkg::CPU_MASK;
         end else begin
            port.rd_byte = port.stored & irq_prio_pkg::CPU_MASK;
            port.wr_ok   = !port.locked;
            port.wr_byte = port.wbyte & irq_prio_pkg::CPU_MASK;
         end
      end
   end
endmodule

// ### src/irq_priority_target_regs.sv
// Interrupt priority and CPU target register arrays behind an APB slave.
// Assumes group membership and lockdown come from distributor logic on mclk.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module irq_priority_target_regs (
   // Clock and reset
   input  wire logic                                         mclk,
   input  wire logic                                         rst,
   // APB slave
   input  wire logic                                         psel,
   input  wire logic                                         penable,
   input  wire logic                                         pwrite,
   input  wire logic [irq_prio_pkg::ADDR_W-1:0]              paddr,
   input  wire logic [31:0]                                  pwdata,
   input  wire logic [3:0]                                   pstrb,
   input  wire logic [2:0]                                   pprot,
   output logic      [31:0]                                  prdata,
   output logic                                              pready,
   output logic                                              pslverr,
   // Distributor context
   input  wire logic [irq_prio_pkg::CPU_ID_W-1:0]            cpu_id,
   input  wire logic [irq_prio_pkg::NUM_IRQ-1:0]             is_group_zero_interrupt,
   input  wire logic                                         config_lockdown,
   // Distributor outputs
   output logic      [irq_prio_pkg::NUM_IRQ-1:0][7:0]        interrupt_priority,
   output logic      [irq_prio_pkg::NUM_SPI-1:0][7:0]        spi_cpu_target
);
   typedef struct packed {
      logic [irq_prio_pkg::NUM_IRQ-1:0][7:0] prio;
      logic [irq_prio_pkg::NUM_SPI-1:0][7:0] tgt;
      logic [31:0]                           prdata;
      logic                                  pslverr;
   } regs_t;

   regs_t                 r;
   regs_t                 next_r;
   logic                  setup;
   logic                  wr_access;
   logic                  nonsecure_access;
   logic                  prio_hit;
   logic                  tgt_hit;
   logic                  mapped;
   logic [7:0]            word_idx;
   logic                  reg_ok;
   logic [7:0]            own_bits;
   logic [3:0][5:0]       lane_m;
   logic [3:0]            lane_impl;
   logic [3:0]            lane_grp0;
   logic [3:0]            lane_locked;
   logic [3:0][7:0]       lane_rd;
   logic [3:0]            lane_ok;
   logic [3:0][7:0]       lane_wr;

   assign setup            = psel && !penable;
   assign wr_access        = psel && penable && pwrite;
   assign nonsecure_access = pprot[1];
   // Each printed offset is a multiple of four, so they are byte addresses
   assign prio_hit = (paddr >= irq_prio_pkg::PRIO_BASE) && (paddr <= irq_prio_pkg::PRIO_LAST);
   assign tgt_hit  = (paddr >= irq_prio_pkg::TARGET_BASE) && (paddr <= irq_prio_pkg::TARGET_LAST);
   assign mapped   = prio_hit || tgt_hit;
   assign word_idx = paddr[9:2];
   assign reg_ok   = word_idx < 8'(irq_prio_pkg::NUM_REGS);
   assign own_bits = irq_prio_pkg::OWN_CPU_BASE << cpu_id;

   generate
      for (genvar i = 0; i < irq_prio_pkg::LANES; i++) begin : g_lane
         lane_if lane_bus ();
         assign lane_m[i]      = {word_idx[3:0], 2'(i)};
         // A uniprocessor build treats every target field as absent
         assign lane_impl[i]   = reg_ok && irq_prio_pkg::IMPLEMENTED[lane_m[i]]
                                 && (prio_hit || irq_prio_pkg::MULTI_PROC);
         assign lane_grp0[i]   = irq_prio_pkg::SECURITY && is_group_zero_interrupt[lane_m[i]];
         assign lane_locked[i] = config_lockdown && lane_m[i][5]
                                 && irq_prio_pkg::LOCKABLE_SPI_MASK[lane_m[i][4:0]]
                                 && is_group_zero_interrupt[lane_m[i]];
         assign lane_bus.is_target    = tgt_hit;
         assign lane_bus.nonsecure    = nonsecure_access;
         assign lane_bus.implemented  = lane_impl[i];
         assign lane_bus.group0       = lane_grp0[i];
         assign lane_bus.banked       = !lane_m[i][5];
         assign lane_bus.fixed        = lane_m[i][5] && irq_prio_pkg::STATIC_SPI_MASK[lane_m[i][4:0]];
         assign lane_bus.locked       = lane_locked[i];
         assign lane_bus.wbyte        = pwdata[8*i +: 8];
         assign lane_bus.stored       = prio_hit ? r.prio[lane_m[i]] : r.tgt[lane_m[i][4:0]];
         assign lane_bus.own_cpu_bits = own_bits;
         assign lane_rd[i]            = lane_bus.rd_byte;
         assign lane_ok[i]            = lane_bus.wr_ok;
         assign lane_wr[i]            = lane_bus.wr_byte;
         irq_lane_access u_lane (
            .port (lane_bus.lane)
         );
      end
      for (genvar k = 0; k < irq_prio_pkg::NUM_SPI; k++) begin : g_spi_out
         // Pending routing follows these live targets; active state is not held here
         assign spi_cpu_target[k] = irq_prio_pkg::STATIC_SPI_MASK[k] ? irq_prio_pkg::STATIC_SPI_TARGET :
                                    irq_prio_pkg::MULTI_PROC ? r.tgt[k] : irq_prio_pkg::OWN_CPU_BASE;
      end
   endgenerate

   always_comb begin
      next_r = r;
      // Read data and error are registered in setup so the access phase needs no wait
      if (setup) begin
         next_r.pslverr = !mapped;
         next_r.prdata  = (mapped && !pwrite) ? lane_rd : irq_prio_pkg::RAZ_WORD;
      end
      if (wr_access && mapped) begin
         for (int i = 0; i < irq_prio_pkg::LANES; i++) begin
            if (pstrb[i] && lane_ok[i]) begin
               if (prio_hit) begin
                  next_r.prio[lane_m[i]] = lane_wr[i];
               end else begin
                  next_r.tgt[lane_m[i][4:0]] = lane_wr[i];
               end
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r <= '{prio:    {irq_prio_pkg::NUM_IRQ{irq_prio_pkg::PRIO_RESET}},
                tgt:     {irq_prio_pkg::NUM_SPI{irq_prio_pkg::TARGET_RESET}},
                prdata:  irq_prio_pkg::RAZ_WORD,
                pslverr: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign pready             = 1'b1;
   assign prdata             = r.prdata;
   assign pslverr            = r.pslverr;
   assign interrupt_priority = r.prio;

   // Helper signals for the checks below
   logic [5:0] a_m0;
   logic [7:0] a_w0;
   logic [7:0] a_old0;
   logic       a_prio_ok0;
   logic       a_prio_rd0;
   assign a_m0       = lane_m[0];
   assign a_w0       = pwdata[7:0];
   assign a_old0     = r.prio[lane_m[0]];
   assign a_prio_ok0 = prio_hit && lane_impl[0] && !(nonsecure_access && lane_grp0[0]);
   assign a_prio_rd0 = setup && !pwrite && a_prio_ok0;
   logic                                  a_fixed0;
   logic [31:0]                           a_grp0_bytes;
   logic [irq_prio_pkg::NUM_IRQ-1:0][7:0] a_grp0_prio;
   logic [irq_prio_pkg::NUM_SPI-1:0][7:0] a_locked_tgt;
   assign a_fixed0     = lane_m[0][5] && irq_prio_pkg::STATIC_SPI_MASK[lane_m[0][4:0]];
   assign a_grp0_bytes = {{8{lane_grp0[3]}}, {8{lane_grp0[2]}}, {8{lane_grp0[1]}}, {8{lane_grp0[0]}}};
   // Views of every group 0 priority field and each lockable group 0 SPI target, so the checks cover all lanes, not only lane 0
   generate
      for (genvar m = 0; m < irq_prio_pkg::NUM_IRQ; m++) begin : g_chk_prio
         assign a_grp0_prio[m] = is_group_zero_interrupt[m] ? interrupt_priority[m] : 8'h00;
      end
      for (genvar k = 0; k < irq_prio_pkg::NUM_SPI; k++) begin : g_chk_tgt
         assign a_locked_tgt[k] = (irq_prio_pkg::LOCKABLE_SPI_MASK[k]
                                   && is_group_zero_interrupt[irq_prio_pkg::NUM_IRQ - irq_prio_pkg::NUM_SPI + k])
                                  ? spi_cpu_target[k] : 8'h00;
      end
   endgenerate

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_ns_prio_write: assert property (
      wr_access && pstrb[0] && nonsecure_access && a_prio_ok0
      |=> interrupt_priority[$past(a_m0)] ==
          ((irq_prio_pkg::PRIO_NS_TOP | {1'b0, $past(a_w0[7:1])}) & irq_prio_pkg::PRIO_MASK))
      else $error("non-secure priority write stored wrong value");
   a_sec_prio_write: assert property (
      wr_access && pstrb[0] && !nonsecure_access && a_prio_ok0
      |=> interrupt_priority[$past(a_m0)] == ($past(a_w0) & irq_prio_pkg::PRIO_MASK))
      else $error("secure priority write stored wrong value");
   a_ns_prio_read: assert property (
      a_prio_rd0 && nonsecure_access
      |=> prdata[7:0] == {$past(a_old0[6:3]), 4'h0})
      else $error("non-secure priority read not shifted");
   a_grp0_hidden: assert property (
      setup && !pwrite && mapped && nonsecure_access && (lane_grp0 != 4'h0)
      ##1 penable |-> (prdata & $past(a_grp0_bytes)) == 32'h0000_0000)
      else $error("group 0 field visible to non-secure read");
   // Membership may move under software control; such cycles are skipped
   a_grp0_no_write: assert property (
      wr_access && prio_hit && nonsecure_access ##1 $stable(is_group_zero_interrupt)
      |-> $stable(a_grp0_prio))
      else $error("non-secure write changed group 0 priority");
   a_unimpl_raz: assert property (
      setup && !pwrite && mapped && !reg_ok |=> prdata == irq_prio_pkg::RAZ_WORD && !pslverr)
      else $error("unimplemented register not read as zero");
   a_banked_own: assert property (
      setup && !pwrite && tgt_hit && reg_ok && !nonsecure_access && lane_impl[0] && !lane_m[0][5]
      |=> prdata[7:0] == $past(own_bits))
      else $error("banked target does not name the reader");
   a_lock_hold: assert property (
      wr_access && tgt_hit && config_lockdown ##1 $stable(is_group_zero_interrupt)
      |-> $stable(a_locked_tgt))
      else $error("locked target field changed");
   a_low_bits: assert property (
      (interrupt_priority & {irq_prio_pkg::NUM_IRQ{~irq_prio_pkg::PRIO_MASK}}) == '0)
      else $error("unimplemented priority bits set");
   a_static_tgt: assert property (
      setup && !pwrite && tgt_hit && a_fixed0 && lane_impl[0] && !(nonsecure_access && lane_grp0[0])
      |=> prdata[7:0] == (irq_prio_pkg::STATIC_SPI_TARGET & irq_prio_pkg::CPU_MASK))
      else $error("fixed target differs from wired value");
   a_byte_lane: assert property (
      wr_access && prio_hit && !pstrb[0] |=> interrupt_priority[$past(a_m0)] == $past(a_old0))
      else $error("unstrobed byte lane changed");
   a_unmapped_err: assert property (
      setup && !mapped ##1 psel && penable |-> pslverr && prdata == irq_prio_pkg::RAZ_WORD)
      else $error("unmapped access not flagged");

   c_ns_write:  cover property (wr_access && prio_hit && nonsecure_access && lane_ok[0] && pstrb[0]);
   c_sec_write: cover property (wr_access && prio_hit && !nonsecure_access && lane_ok[0] && pstrb[0]);
   c_tgt_write: cover property (wr_access && tgt_hit && lane_ok[0] && pstrb[0]);
   c_banked_rd: cover property (setup && !pwrite && tgt_hit && lane_impl[0] && !lane_m[0][5]);
   c_lock_wr:   cover property (wr_access && tgt_hit && (lane_locked != 4'h0));
endmodule

// ### verification/irq_priority_target_regs_tb.sv
// Self-checking bench for the priority and CPU target register arrays.
// Assumes the two-processor, security-enabled build fixed in irq_prio_pkg.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module irq_priority_target_regs_tb;
   logic                                           mclk;
   logic                                           rst;
   logic                                           psel;
   logic                                           penable;
   logic                                           pwrite;
   logic [irq_prio_pkg::ADDR_W-1:0]                paddr;
   logic [31:0]                                    pwdata;
   logic [3:0]                                     pstrb;
   logic [2:0]                                     pprot;
   logic [31:0]                                    prdata;
   logic                                           pready;
   logic                                           pslverr;
   logic [irq_prio_pkg::CPU_ID_W-1:0]              cpu_id;
   logic [irq_prio_pkg::NUM_IRQ-1:0]               is_group_zero_interrupt;
   logic                                           config_lockdown;
   logic [irq_prio_pkg::NUM_IRQ-1:0][7:0]          interrupt_priority;
   logic [irq_prio_pkg::NUM_SPI-1:0][7:0]          spi_cpu_target;
   int                                             n_errors = 0;
   int                                             compares = 0;

   irq_priority_target_regs irq_priority_target_regs_inst (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_id(cpu_id), .is_group_zero_interrupt(is_group_zero_interrupt),
      .config_lockdown(config_lockdown), .interrupt_priority(interrupt_priority),
      .spi_cpu_target(spi_cpu_target));

   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One APB transfer; an idle cycle follows so psel is never assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic ns, output logic [31:0] rd, output logic err);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      pprot   <= {1'b0, ns, 1'b0};
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: no pready", $time);
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic ns);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, s, ns, rd, err);
   endtask

   task automatic chk_rd(input logic [11:0] a, input logic ns, input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0000_0000, 4'h0, ns, rd, err);
      `CHK(rd, exp)
      `CHK(err, experr)
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      pprot = 3'h0;
      cpu_id = 1'b0;
      // Only interrupt 33 is group 0, so one lane shows the group 0 filtering
      is_group_zero_interrupt = 64'h0000_0002_0000_0000;
      config_lockdown = 1'b0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk_rd(12'h420, 1'b0, 32'h0000_0000, 1'b0);
      `CHK(interrupt_priority[32], 8'h00)
      $display("test reset done");
      wr(12'h420, 32'h1234_5678, 4'hF, 1'b0);
      chk_rd(12'h420, 1'b0, 32'h1030_5078, 1'b0);
      `CHK(interrupt_priority[32], 8'h78)
      wr(12'h420, 32'hFFFF_FFFF, 4'h2, 1'b0);
      chk_rd(12'h420, 1'b0, 32'h1030_F878, 1'b0);
      chk_rd(12'h420, 1'b1, 32'h2060_00F0, 1'b0);
      $display("test secure priority done");
      wr(12'h420, 32'h4040_4040, 4'hF, 1'b1);
      chk_rd(12'h420, 1'b0, 32'hA0A0_F8A0, 1'b0);
      chk_rd(12'h420, 1'b1, 32'h4040_0040, 1'b0);
      `CHK(interrupt_priority[33], 8'hF8)
      $display("test nonsecure priority done");
      wr(12'h410, 32'hFFFF_FFFF, 4'hF, 1'b0);
      chk_rd(12'h410, 1'b0, 32'h0000_0000, 1'b0);
      wr(12'h43C, 32'hFFFF_FFFF, 4'hF, 1'b0);
      chk_rd(12'h43C, 1'b0, 32'h0000_0000, 1'b0);
      wr(12'h440, 32'hFFFF_FFFF, 4'hF, 1'b0);
      chk_rd(12'h440, 1'b0, 32'h0000_0000, 1'b0);
      chk_rd(12'hC00, 1'b0, 32'h0000_0000, 1'b1);
      $display("test unimplemented done");
      wr(12'h800, 32'hFFFF_FFFF, 4'hF, 1'b0);
      chk_rd(12'h800, 1'b0, 32'h0101_0101, 1'b0);
      cpu_id <= 1'b1;
      chk_rd(12'h800, 1'b0, 32'h0202_0202, 1'b0);
      cpu_id <= 1'b0;
      $display("test banked targets done");
      wr(12'h820, 32'hFFFF_FFFF, 4'hF, 1'b0);
      chk_rd(12'h820, 1'b0, 32'h0303_0302, 1'b0);
      `CHK(spi_cpu_target[1], 8'h03)
      `CHK(spi_cpu_target[0], 8'h02)
      config_lockdown <= 1'b1;
      wr(12'h820, 32'h0101_0101, 4'hF, 1'b0);
      chk_rd(12'h820, 1'b0, 32'h0101_0302, 1'b0);
      wr(12'h820, 32'h0000_0000, 4'hF, 1'b1);
      chk_rd(12'h820, 1'b1, 32'h0000_0002, 1'b0);
      `CHK(spi_cpu_target[1], 8'h03)
      $display("test spi targets done");
      end_of_test();
   end
endmodule
